// ===== core/bpan_consts.svh
`ifndef BPAN_CONSTS_SVH
`define BPAN_CONSTS_SVH

// register indices; byte address is four times the index
`define BPAN_IDX_CFG     11'h4C0
`define BPAN_IDX_CTL     11'h4C1
`define BPAN_IDX_STAT    11'h4C2
`define BPAN_IDX_BLO     11'h4C3
`define BPAN_IDX_BHI     11'h4C4
`define BPAN_IDX_NLO     11'h4C5
`define BPAN_IDX_NHI     11'h4C6

// configuration word fields
`define BPAN_CFG_EN      0
`define BPAN_CFG_UBASE   1
`define BPAN_CFG_UNEXT   2
`define BPAN_CFG_LRF     3
`define BPAN_CFG_NONCE   4
`define BPAN_CFG_OVR     5
`define BPAN_CFG_RST     6'h01

// command word fields
`define BPAN_CTL_RST     0
`define BPAN_CTL_RESTART 4
`define BPAN_CTL_NP      8

// status word fields
`define BPAN_ST_PGRX     1
`define BPAN_ST_DONE     2
`define BPAN_ST_RF       3
`define BPAN_ST_IDLE     4
`define BPAN_ST_ABLE     5
`define BPAN_ST_LINK     6
`define BPAN_ST_LPABLE   7
`define BPAN_ST_FEC      8
`define BPAN_ST_FAIL     9
`define BPAN_ST_RDY      12

// user base page low word override fields; writable masks of the base page low and high words and the next page low word
`define BPAN_OVR_TECH    16
`define BPAN_OVR_FEC     24
`define BPAN_OVR_PAUSE   28
`define BPAN_BLO_MASK    32'h733FFFFF
`define BPAN_BHI_MASK    32'h3FFFFFFF
`define BPAN_NLO_MASK    32'h0000FFFF

// page constants
`define BPAN_ACK_CLR     16'hBC1F
`define BPAN_NACK_CLR    16'hBFFF
`define BPAN_NULL_NP     16'h2001
`define BPAN_SELECTOR    5'h01

`endif

// ===== core/bpan_page_build.sv
`include "bpan_consts.svh"
`default_nettype none
module bpan_page_build (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // page sources
    input  wire logic        user_base,
    input  wire logic        user_next,
    input  wire logic        np_ready,
    input  wire logic        local_rf,
    input  wire logic [15:0] blo,
    input  wire logic [29:0] bhi,
    input  wire logic [15:0] nlo,
    input  wire logic [31:0] nhi,
    input  wire logic [5:0]  tech,
    input  wire logic [1:0]  fec,
    input  wire logic [2:0]  pause,
    // pages to the transmitter
    output bpan_pkg::bpan_page_t base_page,
    output bpan_pkg::bpan_page_t next_page
);
    import bpan_pkg::*;

    bpan_page_t base_r;
    bpan_page_t base_nxt;
    bpan_page_t next_r;
    bpan_page_t next_nxt;

    // bit 49 (prbs) is never carried here; the transmitter makes it
    always_comb
    begin
        if (user_base)
            base_nxt = {fec, bhi, blo & `BPAN_ACK_CLR};
        else
            base_nxt = {fec, 19'h0, tech, 5'h0, np_ready, 1'b0,
                        local_rf, pause, 5'h0, `BPAN_SELECTOR};
        if (user_next && np_ready)
            next_nxt = {nhi, nlo & `BPAN_NACK_CLR};
        else
            next_nxt = {32'h0, `BPAN_NULL_NP};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            base_r <= 48'h0;
            next_r <= {32'h0, `BPAN_NULL_NP};
        end
        else
        begin
            base_r <= base_nxt;
            next_r <= next_nxt;
        end
    end

    assign base_page = base_r;
    assign next_page = next_r;
endmodule
`default_nettype wire

// ===== core/bpan_pkg.sv
`default_nettype none
package bpan_pkg;

    typedef logic [47:0] bpan_page_t;

    typedef enum logic [2:0] {
        sel_none,
        sel_cfg,
        sel_ctl,
        sel_stat,
        sel_blo,
        sel_bhi,
        sel_nlo,
        sel_nhi
    } bpan_sel_t;

endpackage
`default_nettype wire

// ===== core/bpan_regs.sv
`include "bpan_consts.svh"
`default_nettype none
module bpan_regs #(
    parameter logic [5:0] TECH_DEF  = 6'h04,
    parameter logic [1:0] FEC_DEF   = 2'h0,
    parameter logic [2:0] PAUSE_DEF = 3'h0
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [12:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // negotiation engine status
    input  wire logic             page_rx,
    input  wire logic             rf_sent,
    input  wire logic             an_done,
    input  wire logic             receive_negotiator_idle,
    input  wire logic             link_up,
    input  wire logic             lp_able,
    input  wire logic             fec_on,
    input  wire logic             seq_fail,
    input  wire logic [5:0]       resolved_technology_onehot,
    input  wire logic             tx_in_an,
    input  wire logic             np_taken,
    // negotiation engine control
    output logic                  an_enable,
    output logic                  an_reset,
    output logic                  restart_transmit_negotiator,
    output logic                  np_ready,
    output logic                  force_nonce,
    output logic [5:0]            tech_ability_override,
    output logic [1:0]            fec_ability_override,
    output logic [2:0]            pause_ability_override,
    output bpan_pkg::bpan_page_t  tx_base_page,
    output bpan_pkg::bpan_page_t  extended_page_transmit
);
    import bpan_pkg::*;

    bpan_sel_t   sel;
    logic        acc, wr_fire, rd_fire, ctl_wr, st_rd;
    logic [31:0] stat;
    logic        pg_q, rf_q, lk_q;
    logic        pready_r, pready_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pslverr_r, pslverr_nxt;

    logic [5:0]  cfg_r, cfg_nxt;
    logic [31:0] blo_r, blo_nxt;
    logic [31:0] bhi_r, bhi_nxt;
    logic [31:0] nlo_r, nlo_nxt;
    logic [31:0] nhi_r, nhi_nxt;
    logic        anrst_r, anrst_nxt;
    logic        rstrt_r, rstrt_nxt;
    logic        np_r, np_nxt;
    logic [5:0]  tech_r, tech_nxt;
    logic [1:0]  fec_r, fec_nxt;
    logic [2:0]  pause_r, pause_nxt;

    // address decode; misaligned or unknown words answer with pslverr
    always_comb
    begin
        sel = sel_none;
        if (paddr[1:0] == 2'h0)
        begin
            case (paddr[12:2])
                `BPAN_IDX_CFG:  sel = sel_cfg;
                `BPAN_IDX_CTL:  sel = sel_ctl;
                `BPAN_IDX_STAT: sel = sel_stat;
                `BPAN_IDX_BLO:  sel = sel_blo;
                `BPAN_IDX_BHI:  sel = sel_bhi;
                `BPAN_IDX_NLO:  sel = sel_nlo;
                `BPAN_IDX_NHI:  sel = sel_nhi;
                default:        sel = sel_none;
            endcase
        end
    end

    // one wait state: pready rises the cycle after penable
    assign acc     = psel & penable;
    assign wr_fire = acc & pwrite & pready_r;
    assign rd_fire = acc & ~pwrite & pready_r;
    assign ctl_wr  = wr_fire & (sel == sel_ctl);
    assign st_rd   = rd_fire & (sel == sel_stat);

    // live status image
    always_comb
    begin
        stat = 32'h0;
        stat[`BPAN_ST_PGRX]   = pg_q;
        stat[`BPAN_ST_DONE]   = an_done;
        stat[`BPAN_ST_RF]     = rf_q;
        stat[`BPAN_ST_IDLE]   = receive_negotiator_idle;
        stat[`BPAN_ST_ABLE]   = 1'b1;
        stat[`BPAN_ST_LINK]   = lk_q;
        stat[`BPAN_ST_LPABLE] = lp_able;
        stat[`BPAN_ST_FEC]    = fec_on;
        stat[`BPAN_ST_FAIL]   = seq_fail;
        stat[`BPAN_ST_RDY +: 6] = resolved_technology_onehot;
    end

    // read data is sampled at the first access edge and held one cycle
    always_comb
    begin
        pready_nxt  = acc & ~pready_r;
        prdata_nxt  = 32'h0;
        pslverr_nxt = 1'b0;
        if (acc & ~pready_r)
        begin
            pslverr_nxt = (sel == sel_none);
            if (!pwrite)
            begin
                case (sel)
                    sel_cfg:  prdata_nxt = {26'h0, cfg_r};
                    sel_ctl:  prdata_nxt = {23'h0, np_r, 8'h0};
                    sel_stat: prdata_nxt = stat;
                    sel_blo:  prdata_nxt = blo_r;
                    sel_bhi:  prdata_nxt = bhi_r;
                    sel_nlo:  prdata_nxt = nlo_r;
                    sel_nhi:  prdata_nxt = nhi_r;
                    default:  prdata_nxt = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // storage registers; reserved bits never stored
    always_comb
    begin
        cfg_nxt = cfg_r;
        blo_nxt = blo_r;
        bhi_nxt = bhi_r;
        nlo_nxt = nlo_r;
        nhi_nxt = nhi_r;
        if (wr_fire)
        begin
            case (sel)
                sel_cfg: cfg_nxt = pwdata[5:0];
                sel_blo: blo_nxt = pwdata & `BPAN_BLO_MASK;
                sel_bhi: bhi_nxt = pwdata & `BPAN_BHI_MASK;
                sel_nlo: nlo_nxt = pwdata & `BPAN_NLO_MASK;
                sel_nhi: nhi_nxt = pwdata;
                default: cfg_nxt = cfg_r;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= `BPAN_CFG_RST;
            blo_r <= 32'h0;
            bhi_r <= 32'h0;
            nlo_r <= 32'h0;
            nhi_r <= 32'h0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            blo_r <= blo_nxt;
            bhi_r <= bhi_nxt;
            nlo_r <= nlo_nxt;
            nhi_r <= nhi_nxt;
        end
    end

    // command pulses and the effective advertisement
    always_comb
    begin
        anrst_nxt = ctl_wr & pwdata[`BPAN_CTL_RST];
        rstrt_nxt = ctl_wr & pwdata[`BPAN_CTL_RESTART] & tx_in_an;
        np_nxt    = (ctl_wr & pwdata[`BPAN_CTL_NP]) | (np_r & ~np_taken);
        tech_nxt  = tech_r;
        fec_nxt   = fec_r;
        pause_nxt = pause_r;
        // changing overrides mid-negotiation would corrupt pages in flight
        if (anrst_r)
        begin
            if (cfg_r[`BPAN_CFG_OVR])
            begin
                tech_nxt  = blo_r[`BPAN_OVR_TECH +: 6];
                fec_nxt   = blo_r[`BPAN_OVR_FEC +: 2];
                pause_nxt = blo_r[`BPAN_OVR_PAUSE +: 3];
            end
            else
            begin
                tech_nxt  = TECH_DEF;
                fec_nxt   = FEC_DEF;
                pause_nxt = PAUSE_DEF;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            anrst_r <= 1'b0;
            rstrt_r <= 1'b0;
            np_r    <= 1'b0;
            tech_r  <= TECH_DEF;
            fec_r   <= FEC_DEF;
            pause_r <= PAUSE_DEF;
        end
        else
        begin
            anrst_r <= anrst_nxt;
            rstrt_r <= rstrt_nxt;
            np_r    <= np_nxt;
            tech_r  <= tech_nxt;
            fec_r   <= fec_nxt;
            pause_r <= pause_nxt;
        end
    end

    // only bits reported as one are cleared, so a later event survives
    bpan_sticky u_pgrx (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (page_rx),
        .clr     (st_rd & prdata_r[`BPAN_ST_PGRX]),
        .q       (pg_q)
    );

    bpan_sticky u_rf (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (rf_sent),
        .clr     (st_rd & prdata_r[`BPAN_ST_RF]),
        .q       (rf_q)
    );

    bpan_sticky u_link (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (link_up),
        .clr     (st_rd & prdata_r[`BPAN_ST_LINK]),
        .q       (lk_q)
    );

    bpan_page_build u_page (
        .pclk      (pclk),
        .presetn   (presetn),
        .user_base (cfg_r[`BPAN_CFG_UBASE]),
        .user_next (cfg_r[`BPAN_CFG_UNEXT]),
        .np_ready  (np_r),
        .local_rf  (cfg_r[`BPAN_CFG_LRF]),
        .blo       (blo_r[15:0]),
        .bhi       (bhi_r[29:0]),
        .nlo       (nlo_r[15:0]),
        .nhi       (nhi_r),
        .tech      (tech_r),
        .fec       (fec_r),
        .pause     (pause_r),
        .base_page (tx_base_page),
        .next_page (extended_page_transmit)
    );

    assign pready                      = pready_r;
    assign prdata                      = prdata_r;
    assign pslverr                     = pslverr_r;
    assign an_enable                   = cfg_r[`BPAN_CFG_EN];
    assign an_reset                    = anrst_r;
    assign restart_transmit_negotiator = rstrt_r;
    assign np_ready                    = np_r;
    assign force_nonce                 = cfg_r[`BPAN_CFG_NONCE];
    assign tech_ability_override       = tech_r;
    assign fec_ability_override        = fec_r;
    assign pause_ability_override      = pause_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence rst_cmd;
        ctl_wr && pwdata[`BPAN_CTL_RST];
    endsequence

    sequence rst_pulse;
        an_reset ##1 !an_reset;
    endsequence

    anrst_pulse_a: assert property (rst_cmd |=> rst_pulse)
        else $error("negotiation reset pulse wrong");
    restart_gate_a: assert property (
        restart_transmit_negotiator |-> $past(tx_in_an) && $past(ctl_wr))
        else $error("restart outside negotiation state");
    restart_fire_a: assert property (
        ctl_wr && pwdata[`BPAN_CTL_RESTART] && tx_in_an |=> restart_transmit_negotiator)
        else $error("restart missing");
    np_set_a: assert property (ctl_wr && pwdata[`BPAN_CTL_NP] |=> np_ready)
        else $error("next page ready not set");
    np_clear_a: assert property (np_ready && np_taken && !ctl_wr |=> !np_ready)
        else $error("next page ready not cleared");
    null_page_a: assert property (
        !np_ready |=> extended_page_transmit[15:0] == `BPAN_NULL_NP)
        else $error("null page not sent");
    base_np_a: assert property (
        !cfg_r[`BPAN_CFG_UBASE] |=> tx_base_page[15] == $past(np_ready))
        else $error("next page bit not in D15");
    pgrx_keep_a: assert property (page_rx |=> pg_q [*2])
        else $error("page received lost");
    pgrx_clr_a: assert property (
        st_rd && prdata_r[`BPAN_ST_PGRX] && !page_rx |=> !pg_q)
        else $error("page received not cleared");
    ability_rd_a: assert property (st_rd |-> prdata_r[`BPAN_ST_ABLE])
        else $error("ability bit not one");
    ovr_take_a: assert property (
        an_reset && cfg_r[`BPAN_CFG_OVR]
        |=> tech_ability_override == $past(blo_r[21:16])
            && fec_ability_override == $past(blo_r[25:24]))
        else $error("override not applied");
    ovr_hold_a: assert property (!an_reset |=> $stable(tech_ability_override))
        else $error("advertisement moved without reset");
endmodule
`default_nettype wire

// ===== core/bpan_sticky.sv
`include "bpan_consts.svh"
`default_nettype none
module bpan_sticky (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // event and clear
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    import bpan_pkg::*;

    logic q_r;
    logic q_nxt;

    // set beats clear so an event landing on the read is kept
    always_comb
    begin
        q_nxt = q_r;
        if (clr)
            q_nxt = 1'b0;
        if (set)
            q_nxt = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q_r <= 1'b0;
        else
            q_r <= q_nxt;
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ===== tb/bpan_engine_model.sv
`default_nettype none
module bpan_engine_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // from the register block
    input  wire logic       np_ready,
    input  wire logic       an_reset,
    // pacing set by the bench
    input  wire logic [7:0] take_dly,
    input  wire logic       done_req,
    // to the register block
    output logic            np_taken,
    output logic            an_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_r;
    // a slow delay keeps the page visible long enough to be checked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_r   <= 8'h00;
            np_taken <= 1'b0;
            an_done  <= 1'b0;
        end
        else
        begin
            np_taken <= 1'b0;
            if (np_ready && !np_taken)
            begin
                wait_r <= wait_r + 8'h01;
                if (wait_r >= take_dly)
                begin
                    np_taken <= 1'b1;
                    wait_r   <= 8'h00;
                end
            end
            if (an_reset)
                an_done <= 1'b0;
            else if (done_req)
                an_done <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [12:0] paddr = 13'h0000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    logic        page_rx = 1'b0, rf_sent = 1'b0, idle = 1'b0, link_up = 1'b0;
    logic        lp_able = 1'b0, fec_on = 1'b0, seq_fail = 1'b0, tx_in_an = 1'b0;
    logic [5:0]  onehot = 6'h00;
    logic        an_done, np_taken, an_enable, an_reset, restart, np_ready, force_nonce;
    logic [7:0]  take_dly = 8'h28;
    logic        done_req = 1'b0;
    logic [5:0]  tech;
    logic [1:0]  fec;
    logic [2:0]  pause;
    bpan_pkg::bpan_page_t base_pg, ext_pg;
    int          errors = 0, checked = 0, cycles = 0, rst_cnt = 0, rs_cnt = 0;
    logic [31:0] q;
    logic        e;

    always #10 pclk = ~pclk;

    bpan_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .page_rx(page_rx), .rf_sent(rf_sent), .an_done(an_done),
        .receive_negotiator_idle(idle), .link_up(link_up), .lp_able(lp_able),
        .fec_on(fec_on), .seq_fail(seq_fail), .resolved_technology_onehot(onehot),
        .tx_in_an(tx_in_an), .np_taken(np_taken), .an_enable(an_enable),
        .an_reset(an_reset), .restart_transmit_negotiator(restart), .np_ready(np_ready),
        .force_nonce(force_nonce), .tech_ability_override(tech),
        .fec_ability_override(fec), .pause_ability_override(pause),
        .tx_base_page(base_pg), .extended_page_transmit(ext_pg));

    bpan_engine_model eng_u (.pclk(pclk), .presetn(presetn), .np_ready(np_ready),
        .an_reset(an_reset), .take_dly(take_dly), .done_req(done_req),
        .np_taken(np_taken), .an_done(an_done));

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (an_reset === 1'b1) rst_cnt <= rst_cnt + 1;
        if (restart === 1'b1) rs_cnt <= rs_cnt + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
        checked = checked + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // waits for pready however long it takes; only the cycle watchdog ends a hang
    task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk({16'h0, q}, {16'h0, exp}, m);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic t_reset_vals;
        rd_chk(13'h1300, 32'h00000001, "cfg reset");
        chk({an_enable, force_nonce}, 2'h2, "enable and nonce defaults");
        chk(ext_pg, {32'h0, 16'h2001}, "null page at reset");
        chk({tech, fec, pause}, {6'h04, 2'h0, 3'h0}, "override defaults");
    endtask

    task automatic t_status;
        @(posedge pclk);
        page_rx <= 1'b1;
        rf_sent <= 1'b1;
        link_up <= 1'b1;
        {idle, lp_able, fec_on, seq_fail, done_req} <= 5'h1F;
        onehot <= 6'b001000;
        @(posedge pclk);
        {page_rx, rf_sent, link_up, done_req} <= 4'h0;
        rd_chk(13'h1308, 32'h000083FE, "status all set");
        rd_chk(13'h1308, 32'h000083B4, "sticky cleared");
        {idle, lp_able, fec_on, seq_fail} <= 4'h0;
        onehot <= 6'h00;
    endtask

    task automatic t_reset_cmd;
        int b;
        b = rst_cnt;
        apb(1'b1, 13'h1304, 32'h00000001);
        wait_cyc(4);
        chk(rst_cnt - b, 1, "one reset pulse");
        rd_chk(13'h1304, 32'h00000000, "reset self clears");
        rd_chk(13'h1308, 32'h00000020, "status after reset");
    endtask

    task automatic t_restart;
        int b;
        b = rs_cnt;
        apb(1'b1, 13'h1304, 32'h00000010);
        wait_cyc(4);
        chk(rs_cnt - b, 0, "restart outside negotiation");
        @(posedge pclk);
        tx_in_an <= 1'b1;
        apb(1'b1, 13'h1304, 32'h00000010);
        wait_cyc(4);
        chk(rs_cnt - b, 1, "restart in negotiation");
        rd_chk(13'h1304, 32'h00000000, "restart self clears");
    endtask

    task automatic t_next_page;
        int n;
        n = 0;
        apb(1'b1, 13'h1300, 32'h00000005);
        apb(1'b1, 13'h1314, 32'hFFFFAB5A);
        apb(1'b1, 13'h1318, 32'h12345678);
        take_dly <= 8'h28;
        apb(1'b1, 13'h1304, 32'h00000100);
        wait_cyc(3);
        chk(np_ready, 1'b1, "next page ready");
        chk(ext_pg, {32'h12345678, 16'hAB5A}, "user next page");
        chk(base_pg[15], 1'b1, "more pages flag");
        rd_chk(13'h1304, 32'h00000100, "ready readback");
        while (np_ready === 1'b1 && n < 100)
        begin
            wait_cyc(1);
            n = n + 1;
        end
        wait_cyc(2);
        chk(np_ready, 1'b0, "ready self clears");
        chk(ext_pg[15:0], 16'h2001, "null after use");
        chk(base_pg[15], 1'b0, "flag dropped");
        apb(1'b1, 13'h1300, 32'h00000001);
        take_dly <= 8'h01;
        apb(1'b1, 13'h1304, 32'h00000100);
        wait_cyc(2);
        chk(ext_pg[15:0], 16'h2001, "null with user pages off");
    endtask

    task automatic t_base_page;
        apb(1'b1, 13'h1300, 32'h00000019);
        wait_cyc(3);
        chk(force_nonce, 1'b1, "nonce forced");
        chk({base_pg[15:13], base_pg[4:0]}, {3'b001, 5'h01}, "generated page");
        apb(1'b1, 13'h130C, 32'hFFEABFFF);
        apb(1'b1, 13'h1310, 32'hEAAAAAAA);
        rd_chk(13'h130C, 32'h732ABFFF, "low word mask");
        rd_chk(13'h1310, 32'h2AAAAAAA, "high word mask");
        apb(1'b1, 13'h1300, 32'h00000003);
        wait_cyc(3);
        chk(base_pg[15:0], 48'hBC1F, "user base low");
        chk(base_pg[45:16], 48'h2AAAAAAA, "user base high");
        chk(base_pg[47:46], 2'b00, "default fec");
    endtask

    task automatic t_override;
        apb(1'b1, 13'h130C, 32'h532ABFFF);
        apb(1'b1, 13'h1304, 32'h00000001);
        wait_cyc(4);
        chk({tech, fec, pause}, {6'h04, 2'h0, 3'h0}, "no override when off");
        apb(1'b1, 13'h1300, 32'h00000023);
        wait_cyc(3);
        chk({tech, fec, pause}, {6'h04, 2'h0, 3'h0}, "waits for reset");
        apb(1'b1, 13'h1304, 32'h00000001);
        wait_cyc(4);
        chk({tech, fec, pause}, {6'h2A, 2'h3, 3'h5}, "override applied");
        chk(base_pg[47:46], 2'b11, "page fec follows");
    endtask

    task automatic t_unmapped;
        apb(1'b0, 13'h131C, 32'h0);
        chk({q, e}, {32'h0, 1'b1}, "unmapped read");
        apb(1'b1, 13'h1301, 32'h00000000);
        chk(e, 1'b1, "misaligned write");
        rd_chk(13'h1300, 32'h00000023, "cfg untouched");
    endtask

    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_status();
        t_reset_cmd();
        t_restart();
        t_next_page();
        t_base_page();
        t_override();
        t_unmapped();
        report_and_stop();
    end
endmodule
`default_nettype wire
